/* tcci_params.svh */
// Constants of the timer control and event-reporting block: register offsets,
// field positions, reset values and internal timing counts.
// Assumes it is included by bare name into packages and modules that need it.
`ifndef TCCI_PARAMS_SVH
`define TCCI_PARAMS_SVH

// Register byte offsets on the register port.
`define TCCI_OFF_CMD_STAT     12'h000
`define TCCI_OFF_STATUS       12'h020
`define TCCI_OFF_INT_VIEW     12'h024
`define TCCI_OFF_INT_MASK     12'h028
`define TCCI_OFF_CNT_VALUE    12'h050
`define TCCI_OFF_CNT_UPPER    12'h060

// Command and status fields of the command/status register.
`define TCCI_BIT_GO           0
`define TCCI_BIT_HALT         1
`define TCCI_BIT_CLEAR        2
`define TCCI_BIT_RUNNING      16
`define TCCI_BIT_CLR_DONE     17
`define TCCI_BIT_RST_RELEASED 18

// Field positions of the event status, mask and interrupt view registers.
`define TCCI_POS_EVENT_LO     0
`define TCCI_POS_FAULT_LO     8
`define TCCI_POS_TOP          16
`define TCCI_POS_OVR_A        24
`define TCCI_POS_OVR_B        25

// Defined bits of the status layout and reset values.
`define TCCI_FLAG_VALID       32'h0301_3F3F
`define TCCI_MASK_RESET       32'h0301_3F3F
`define TCCI_UPPER_RESET      32'hFFFF_FFFF
`define TCCI_ZERO32           32'h0000_0000

// Internal settle time of a go, halt or clear command and its cycle count.
`define TCCI_CLK_PERIOD_NS    100
`define TCCI_SETTLE_NS        300
`define TCCI_SETTLE_CYC       ((`TCCI_SETTLE_NS + `TCCI_CLK_PERIOD_NS - 1) / `TCCI_CLK_PERIOD_NS)

`endif

/* tcci_pkg.sv */
// Types shared by the timer control block: state enum and state structs.
// Assumes tcci_params.svh is on the include path.
package tcci_pkg;

  // Running-state of the main counter as seen from the bus side.
  typedef enum logic [1:0] {
    RUN_OFF,
    RUN_ARMING,
    RUN_ON,
    RUN_DISARMING
  } tcci_run_e;

  // Whole state of the counter core.
  typedef struct packed {
    tcci_run_e   run_st;
    logic [3:0]  run_lat;
    logic        clr_busy;
    logic [3:0]  clr_lat;
    logic        clr_done;
    logic [31:0] count;
    logic        top_hit;
    logic        chan_clr;
  } tcci_core_s;

  // Whole state of the sticky flag bank.
  typedef struct packed {
    logic [31:0] flags;
  } tcci_flag_s;

  // Whole state of the top level.
  typedef struct packed {
    logic [31:0] rdata;
    logic [31:0] mask;
    logic [31:0] upper;
    logic        rst_seen;
    logic [1:0]  cap_pend;
    logic        go;
    logic        halt;
    logic        clr;
  } tcci_top_s;

endpackage

/* tcci_ctl_if.sv */
// Interface between the top level and the counter core.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface tcci_ctl_if;
  logic        go;        // One-cycle start command.
  logic        halt;      // One-cycle stop command.
  logic        clr;       // One-cycle clear command.
  logic [31:0] upper;     // Programmed top value.
  logic        run;       // Counter enabled internally.
  logic        clr_done;  // Last clear has completed.
  logic [31:0] count;     // Main counter value.
  logic        top_hit;   // One-cycle pulse when the top value is reached.
  logic        chan_clr;  // One-cycle pulse that zeroes channel outputs.

  modport core (input go, halt, clr, upper, output run, clr_done, count, top_hit, chan_clr);
  modport ctl  (output go, halt, clr, upper, input run, clr_done, count, top_hit, chan_clr);
endinterface

/* tcci_cnt_core.sv */
// Main counter with lagging run status and a timed clear sequence.
// Assumes one-cycle command pulses from the control side on the same clock.
`timescale 1ns/1ps
`include "tcci_params.svh"
module tcci_cnt_core #(
  parameter int SETTLE_CYC = `TCCI_SETTLE_CYC
) (
  input  wire logic i_clk,
  input  wire logic i_rst,
  tcci_ctl_if.core  ctl
);
  import tcci_pkg::*;

  localparam logic [3:0] LAT_LOAD = 4'(SETTLE_CYC - 1);

  tcci_core_s st_r;   // Registered state.
  tcci_core_s st_nxt; // Next state.

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic: run state, clear sequence and counting.
  always_comb begin
    st_nxt          = st_r;
    st_nxt.top_hit  = 1'b0;
    st_nxt.chan_clr = 1'b0;
    // Status reads 1 only after the settle delay, lagging the command.
    case (st_r.run_st)
      RUN_OFF: begin
        if (ctl.go && !ctl.halt) begin // [RL5]
          st_nxt.run_st  = RUN_ARMING;
          st_nxt.run_lat = LAT_LOAD;
        end
      end
      RUN_ARMING: begin
        if (ctl.halt) begin // [RL6]
          st_nxt.run_st = RUN_OFF;
        end else if (st_r.run_lat == 4'h0) begin
          st_nxt.run_st = RUN_ON; // [RL7]
        end else begin
          st_nxt.run_lat = st_r.run_lat - 4'h1;
        end
      end
      RUN_ON: begin
        if (ctl.halt) begin // [RL6]
          st_nxt.run_st  = RUN_DISARMING;
          st_nxt.run_lat = LAT_LOAD;
        end
      end
      RUN_DISARMING: begin
        // The counter still counts until the stop really lands.
        if (ctl.go && !ctl.halt) begin
          st_nxt.run_st = RUN_ON;
        end else if (st_r.run_lat == 4'h0) begin
          st_nxt.run_st = RUN_OFF; // [RL7]
        end else begin
          st_nxt.run_lat = st_r.run_lat - 4'h1;
        end
      end
      default: begin
        st_nxt.run_st = RUN_OFF;
      end
    endcase
    // Counting while enabled; wrap to zero at the top value.
    if (st_r.run_st == RUN_ON || st_r.run_st == RUN_DISARMING) begin
      if (st_r.count == ctl.upper) begin
        st_nxt.count   = `TCCI_ZERO32;
        st_nxt.top_hit = 1'b1; // [RL10]
      end else begin
        st_nxt.count = st_r.count + 32'h0000_0001;
      end
    end
    // Clear sequence: done drops at once and returns when the clear lands.
    if (ctl.clr) begin
      st_nxt.clr_busy = 1'b1;
      st_nxt.clr_lat  = LAT_LOAD;
      st_nxt.clr_done = 1'b0; // [RL2]
    end else if (st_r.clr_busy) begin
      if (st_r.clr_lat == 4'h0) begin
        st_nxt.clr_busy = 1'b0;
        st_nxt.clr_done = 1'b1; // [RL2]
        st_nxt.count    = `TCCI_ZERO32; // [RL3]
        st_nxt.chan_clr = 1'b1; // [RL3]
        st_nxt.top_hit  = 1'b0;
      end else begin
        st_nxt.clr_lat = st_r.clr_lat - 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_r <= '{run_st: RUN_OFF, default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign ctl.run      = (st_r.run_st == RUN_ON) || (st_r.run_st == RUN_DISARMING);
  assign ctl.clr_done = st_r.clr_done;
  assign ctl.count    = st_r.count;
  assign ctl.top_hit  = st_r.top_hit;
  assign ctl.chan_clr = st_r.chan_clr;
endmodule

/* tcci_flag_bank.sv */
// Sticky write-one-to-clear flag bank with set-over-clear priority.
// Assumes set and clear vectors come from logic on the same clock.
`timescale 1ns/1ps
module tcci_flag_bank #(
  parameter int          W     = 32,
  parameter logic [31:0] VALID = 32'hFFFF_FFFF
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_set,
  input  wire logic [W-1:0] i_clr,
  output logic      [W-1:0] o_flags
);
  import tcci_pkg::*;

  tcci_flag_s   st_r;    // Registered flags.
  tcci_flag_s   st_nxt;  // Next flags.
  logic [W-1:0] bit_nxt; // Per-bit next value from the generate loop.

  ////////////////////////////////////////////////////////////////////////////
  // Each bit holds until cleared; a set in the clearing cycle wins, so an
  // event that lands while software clears is never lost.
  // Undefined bits are tied to zero so reserved places read harmless.
  for (genvar b = 0; b < W; b++) begin : g_bit
    assign bit_nxt[b] = VALID[b] ? (i_set[b] | (st_r.flags[b] & ~i_clr[b])) : 1'b0; // [RL17]
  end

  // Whole next state is filled in one place.
  always_comb begin
    st_nxt       = st_r;
    st_nxt.flags = 32'(bit_nxt);
  end

  // Flags come up cleared.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_flags = st_r.flags[W-1:0];
endmodule

/* tcci_top.sv */
// Top of the timer control and event-reporting block: register port,
// command decode, event status, mask, interrupt view and interrupt line.
// Assumes event, capture and DMA inputs come from channel logic on i_clk.
`timescale 1ns/1ps
`include "tcci_params.svh"

// Functional notes
// [RL1] Reset-released bit reads 0, then 1.
// [RL2] Clear drops done bit until clear completes.
// [RL3] Clear zeroes counter and channel outputs.
// [RL4] Software waits for clear done before writing.
// [RL5] Go enables counter; zero writes do nothing.
// [RL6] Halt disables counter; poll running bit.
// [RL7] Running bit lags real enable and disable.
// [RL8] Six channel event flags, write-one clear.
// [RL9] Six channel fault flags, write-one clear.
// [RL10] Top-reached flag set at upper value.
// [RL11] Capture DMA overrun flags, write-one clear.
// [RL12] View bit is status unless masked.
// [RL13] Interrupt high while any view bit set.
// [RL14] View read-only, same layout, reset zero.
// [RL15] Reserved bits read zero, writes ignored.
// [RL16] Mask one suppresses; mask resets to ones.
// [RL17] Set wins over same-cycle clear.
// [RL18] Command bits are pulses, read zero.
module tcci_top #(
  parameter int SETTLE_CYC = `TCCI_SETTLE_CYC
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic [11:0] i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  input  wire logic [5:0]  i_chan_event,
  input  wire logic [5:0]  i_chan_fault,
  input  wire logic [1:0]  i_capture,
  input  wire logic [1:0]  i_dma_taken,
  output logic      [31:0] o_count,
  output logic             o_chan_clear,
  output logic             o_irq
);
  import tcci_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode helper, used by both the write and the read paths.
  function automatic logic hit(input logic [11:0] addr, input logic [11:0] off);
    hit = (addr == off);
  endfunction

  tcci_top_s   st_r;       // Registered state.
  tcci_top_s   st_nxt;     // Next state.
  tcci_ctl_if  ctl ();     // Link to the counter core.
  logic [31:0] status;     // Sticky event flags.
  logic [31:0] flag_set;   // Hardware set vector.
  logic [31:0] flag_clr;   // Software write-one-to-clear vector.
  logic [31:0] int_view;   // Masked interrupt view.
  logic [1:0]  overrun;    // Capture overrun events.
  logic        wr_cmd;     // Write to the command/status register.
  logic        wr_status;  // Write to the event status register.
  logic        wr_mask;    // Write to the mask register.
  logic        wr_upper;   // Write to the upper value register.

  ////////////////////////////////////////////////////////////////////////////
  // Counter core and sticky flag bank.
  tcci_cnt_core #(
    .SETTLE_CYC (SETTLE_CYC)
  ) u_core (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .ctl   (ctl)
  );

  tcci_flag_bank #(
    .W     (32),
    .VALID (`TCCI_FLAG_VALID)
  ) u_flags (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_set   (flag_set),
    .i_clr   (flag_clr),
    .o_flags (status)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Write decode. Writes to read-only or reserved places are dropped.
  assign wr_cmd    = i_wr && hit(i_addr, `TCCI_OFF_CMD_STAT);
  assign wr_status = i_wr && hit(i_addr, `TCCI_OFF_STATUS);
  assign wr_mask   = i_wr && hit(i_addr, `TCCI_OFF_INT_MASK);
  assign wr_upper  = i_wr && hit(i_addr, `TCCI_OFF_CNT_UPPER);

  // Overrun when a new capture meets data the DMA has not yet taken.
  // A take in the same cycle empties the slot first, so no overrun then.
  for (genvar d = 0; d < 2; d++) begin : g_ovr
    assign overrun[d] = i_capture[d] && st_r.cap_pend[d] && !i_dma_taken[d]; // [RL11]
  end

  // Hardware set sources placed at their status positions.
  always_comb begin
    flag_set = `TCCI_ZERO32;
    flag_set[`TCCI_POS_EVENT_LO +: 6] = i_chan_event; // [RL8]
    flag_set[`TCCI_POS_FAULT_LO +: 6] = i_chan_fault; // [RL9]
    flag_set[`TCCI_POS_TOP]           = ctl.top_hit; // [RL10]
    flag_set[`TCCI_POS_OVR_A]         = overrun[0]; // [RL11]
    flag_set[`TCCI_POS_OVR_B]         = overrun[1]; // [RL11]
  end

  // Software clears with ones; the bank keeps a set that lands together.
  assign flag_clr = wr_status ? i_wdata : `TCCI_ZERO32; // [RL8] [RL9] [RL17]

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt view and line. The view is pure logic over two registers,
  // so it never needs its own reset and is zero while status is zero.
  assign int_view = status & ~st_r.mask & `TCCI_FLAG_VALID; // [RL12] [RL14]
  assign o_irq    = |int_view; // [RL13]

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic: commands, registers and read data.
  always_comb begin
    st_nxt = st_r;
    // Reset release is seen on the first edge after reset drops.
    st_nxt.rst_seen = 1'b1; // [RL1]
    // Command bits are one-cycle pulses and are never stored.
    // A halt written with a go in one word wins over the go.
    st_nxt.go   = wr_cmd && i_wdata[`TCCI_BIT_GO] && !i_wdata[`TCCI_BIT_HALT]; // [RL5] [RL18]
    st_nxt.halt = wr_cmd && i_wdata[`TCCI_BIT_HALT]; // [RL6] [RL18]
    st_nxt.clr  = wr_cmd && i_wdata[`TCCI_BIT_CLEAR]; // [RL3] [RL18]
    // Mask holds only defined bits; reserved bits stay zero.
    if (wr_mask) begin
      st_nxt.mask = i_wdata & `TCCI_FLAG_VALID; // [RL16] [RL15]
    end
    if (wr_upper) begin
      st_nxt.upper = i_wdata;
    end
    // Capture slots fill on capture and empty when the DMA takes them.
    for (int d = 0; d < 2; d++) begin
      if (i_capture[d]) begin
        st_nxt.cap_pend[d] = 1'b1;
      end else if (i_dma_taken[d]) begin
        st_nxt.cap_pend[d] = 1'b0;
      end
    end
    // Read data stand only in the cycle after the read strobe.
    st_nxt.rdata = `TCCI_ZERO32;
    if (i_rd) begin
      if (hit(i_addr, `TCCI_OFF_CMD_STAT)) begin
        // Command bits read zero; reserved bits read zero.
        st_nxt.rdata[`TCCI_BIT_RST_RELEASED] = st_r.rst_seen; // [RL1] [RL18]
        st_nxt.rdata[`TCCI_BIT_CLR_DONE]     = ctl.clr_done; // [RL2]
        st_nxt.rdata[`TCCI_BIT_RUNNING]      = ctl.run; // [RL7]
      end else if (hit(i_addr, `TCCI_OFF_STATUS)) begin
        st_nxt.rdata = status; // [RL15]
      end else if (hit(i_addr, `TCCI_OFF_INT_VIEW)) begin
        st_nxt.rdata = int_view; // [RL14]
      end else if (hit(i_addr, `TCCI_OFF_INT_MASK)) begin
        st_nxt.rdata = st_r.mask;
      end else if (hit(i_addr, `TCCI_OFF_CNT_VALUE)) begin
        st_nxt.rdata = ctl.count;
      end else if (hit(i_addr, `TCCI_OFF_CNT_UPPER)) begin
        st_nxt.rdata = st_r.upper;
      end else begin
        // Unmapped addresses answer with zero.
        st_nxt.rdata = `TCCI_ZERO32;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register. The mask comes up with every defined bit set so no event interrupts
  // before software has chosen what it wants to see.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_r <= '{mask: `TCCI_MASK_RESET, upper: `TCCI_UPPER_RESET, default: '0}; // [RL16]
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core hookup and outputs.
  assign ctl.go       = st_r.go;
  assign ctl.halt     = st_r.halt;
  assign ctl.clr      = st_r.clr;
  assign ctl.upper    = st_r.upper;
  assign o_rdata      = st_r.rdata;
  assign o_count      = ctl.count;
  assign o_chan_clear = ctl.chan_clr; // [RL3]
endmodule

/* tcci_top_sva.sv */
// Checker for the timer control block; it sees only the top-level ports.
// Assumes one clock, strobes that never overlap and a small settle count.
`timescale 1ns/1ps
`include "tcci_params.svh"
module tcci_top_sva #(
  parameter int SETTLE_CYC = `TCCI_SETTLE_CYC
) (
  input wire logic        i_clk,
  input wire logic        i_rst,
  input wire logic [11:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic [5:0]  i_chan_event,
  input wire logic [5:0]  i_chan_fault,
  input wire logic [1:0]  i_capture,
  input wire logic [1:0]  i_dma_taken,
  input wire logic [31:0] o_count,
  input wire logic        o_chan_clear,
  input wire logic        o_irq
);
  localparam logic [31:0] VLD   = `TCCI_FLAG_VALID;    // Defined flag bits.
  localparam logic [11:0] A_CMD = `TCCI_OFF_CMD_STAT;  // Command and status place.
  localparam logic [11:0] A_ST  = `TCCI_OFF_STATUS;    // Sticky status place.
  localparam logic [11:0] A_VW  = `TCCI_OFF_INT_VIEW;  // Masked view place.
  localparam logic [11:0] A_MK  = `TCCI_OFF_INT_MASK;  // Mask place.

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  // A read strobe at one place.
  sequence rd_at(logic [11:0] a);
    i_rd && i_addr == a;
  endsequence
  // A clear command written to the command place.
  sequence clr_cmd;
    i_wr && i_addr == A_CMD && i_wdata[`TCCI_BIT_CLEAR];
  endsequence
  // The clear lands as a single-cycle pulse.
  sequence clr_land;
    o_chan_clear ##1 !o_chan_clear;
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  AST_RDATA_IDLE: assert property (!i_rd |=> o_rdata == 32'h0000_0000)
    else $error("read data not zero outside a read answer");
  AST_RST_DONE: assert property (rd_at(A_CMD) |=> o_rdata[18])
    else $error("reset released bit reads zero");
  AST_CMD_RSV: assert property (rd_at(A_CMD) |=> (o_rdata & 32'hFFF8_FFFF) == 0)
    else $error("command bits or reserved bits read nonzero");
  AST_STAT_RSV: assert property (rd_at(A_ST) |=> (o_rdata & ~VLD) == 0)
    else $error("status reserved bits read nonzero");
  AST_VIEW_RSV: assert property (rd_at(A_VW) |=> (o_rdata & ~VLD) == 0)
    else $error("view reserved bits read nonzero");
  AST_IRQ_VIEW: assert property (rd_at(A_VW) |=> (o_rdata != 0) == $past(o_irq))
    else $error("interrupt line disagrees with the view");
  AST_MASK_ALL: assert property (i_wr && i_addr == A_MK && (i_wdata & VLD) == VLD |=> !o_irq)
    else $error("interrupt raised with every bit masked");
  AST_CLR_LOW: assert property (clr_cmd ##2 rd_at(A_CMD) |=> !o_rdata[17])
    else $error("clear done still high just after a clear");
  AST_CLR_LAND: assert property (clr_cmd |-> ##[2:8] clr_land)
    else $error("clear did not land as one pulse in time");
  AST_CLR_ZERO: assert property (o_chan_clear |-> o_count == 32'h0000_0000)
    else $error("counter not zero when the clear lands");
  AST_CNT_STEP: assert property (o_count == $past(o_count) || o_count == 32'h0000_0000 ||
                                 o_count == $past(o_count) + 32'h0000_0001)
    else $error("counter moved by more than one step");
endmodule

bind tcci_top tcci_top_sva #(.SETTLE_CYC(SETTLE_CYC)) tcci_top_sva_i (
  .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .i_chan_event(i_chan_event),
  .i_chan_fault(i_chan_fault), .i_capture(i_capture), .i_dma_taken(i_dma_taken),
  .o_count(o_count), .o_chan_clear(o_chan_clear), .o_irq(o_irq));

/* test_tcci_top.sv */
// Self-checking bench for the timer control block, random flags among corner cases.
// Assumes the design files and the checker are compiled before it.
`timescale 1ns/1ps
`include "tcci_params.svh"
module test_tcci_top;
  localparam logic [31:0] VLD   = `TCCI_FLAG_VALID;    // Defined flag bits.
  localparam logic [11:0] A_CMD = `TCCI_OFF_CMD_STAT;  // Command and status place.
  localparam logic [11:0] A_ST  = `TCCI_OFF_STATUS;    // Sticky status place.
  localparam logic [11:0] A_VW  = `TCCI_OFF_INT_VIEW;  // Masked view place.
  localparam logic [11:0] A_MK  = `TCCI_OFF_INT_MASK;  // Mask place.
  localparam logic [11:0] A_CV  = `TCCI_OFF_CNT_VALUE; // Counter value place.
  localparam logic [11:0] A_UP  = `TCCI_OFF_CNT_UPPER; // Upper value place.
  localparam logic [11:0] RA [5] = '{A_CMD, A_ST, A_VW, A_MK, 12'h100};
  localparam logic [31:0] RV [5] = '{32'h0004_0000, 32'h0000_0000, 32'h0000_0000, VLD,
                                     32'h0000_0000};
  logic        i_clk        = 1'b0;  // Bus clock.
  logic        i_rst        = 1'b1;  // Reset, high at start.
  logic [11:0] i_addr       = '0;    // Register address.
  logic [31:0] i_wdata      = '0;    // Write data.
  logic        i_wr         = 1'b0;  // Write strobe.
  logic        i_rd         = 1'b0;  // Read strobe.
  logic [5:0]  i_chan_event = '0;    // Channel events.
  logic [5:0]  i_chan_fault = '0;    // Channel faults.
  logic [1:0]  i_capture    = '0;    // New captures.
  logic [1:0]  i_dma_taken  = '0;    // Captures taken away.
  logic [31:0] o_rdata;              // Read answer.
  logic [31:0] o_count;              // Main counter.
  logic        o_chan_clear;         // Clear landing pulse.
  logic        o_irq;                // Interrupt line.
  int          errors       = 0;     // Mismatch count.
  int          n_checks     = 0;     // Comparison count.
  int          n_land       = 0;     // Clear pulses seen.
  int          i;                    // Loop index.
  logic [31:0] d, c0, st, mk, ev;    // Read value, saved count and flag model.

  tcci_top tcci_top_i (
    .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_chan_event(i_chan_event),
    .i_chan_fault(i_chan_fault), .i_capture(i_capture), .i_dma_taken(i_dma_taken),
    .o_count(o_count), .o_chan_clear(o_chan_clear), .o_irq(o_irq));

  // Clock of 100 ns.
  always #50 i_clk = ~i_clk;
  // Count clear landings; a pulse longer than one cycle shows as extra counts.
  always @(posedge i_clk) if (o_chan_clear === 1'b1) n_land <= n_land + 1;

  ////////////////////////////////////////////////////////////////////////////
  // Expected view: status passed where the mask is clear.
  function automatic logic [31:0] view_of(logic [31:0] s, logic [31:0] m);
    return s & ~m & VLD;
  endfunction
  // Print the counts and the verdict, then stop.
  task automatic results();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Compare one value and report a mismatch.
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One bus cycle with channel inputs in status layout; faults land in 13:8.
  task automatic cyc(logic w, logic [11:0] a, logic [31:0] v, logic [31:0] s);
    @(posedge i_clk);
    i_wr <= w;
    i_addr <= a;
    i_wdata <= v;
    i_chan_event <= s[5:0];
    i_chan_fault <= s[13:8];
    i_capture <= s[25:24];
    i_dma_taken <= s[29:28];
    @(posedge i_clk);
    i_wr <= 1'b0;
    i_chan_event <= '0;
    i_chan_fault <= '0;
    i_capture <= '0;
    i_dma_taken <= '0;
  endtask
  // Read one word; the answer is taken in the cycle after the strobe only.
  task automatic rd(logic [11:0] a);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  // Poll one bit for a value, bounded; running out ends the run.
  task automatic poll(logic [11:0] a, int b, logic v);
    int k;
    k = 0;
    rd(a);
    while (d[b] !== v && k < 40) begin
      rd(a);
      k++;
    end
    chk("poll", 32'(v), 32'(d[b]));
    if (k == 40) results();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Hang guard.
  initial begin
    repeat (20000) @(posedge i_clk);
    errors++;
    results();
  end
  // Main sequence.
  initial begin
    void'($urandom(32'h263e_2908));
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    // Software waits for the reset-released bit before touching anything else.
    poll(A_CMD, 18, 1'b1);
    for (i = 0; i < 5; i++) begin
      rd(RA[i]);
      chk("reset value", RV[i], d);
    end
    cyc(1'b1, A_CMD, 32'h0000_0001, '0);
    rd(A_CMD);
    chk("running lag", 32'h0000_0000, 32'(d[16]));
    poll(A_CMD, 16, 1'b1);
    rd(A_CV);
    c0 = d;
    rd(A_CV);
    chk("count step", c0 + 32'h0000_0002, d);
    cyc(1'b1, A_CMD, 32'h0000_0000, '0);
    rd(A_CMD);
    chk("zero write", 32'h0000_0001, 32'(d[16]));
    cyc(1'b1, A_CMD, 32'h0000_0003, '0);
    poll(A_CMD, 16, 1'b0);
    rd(A_CV);
    c0 = d;
    rd(A_CV);
    chk("halted", c0, d);
    chk("count pin", c0, o_count);
    // Two clears: the second starts from done high, so the drop is visible.
    for (i = 0; i < 2; i++) begin
      cyc(1'b1, A_CMD, 32'h0000_0004, '0);
      rd(A_CMD);
      chk("clear busy", 32'h0000_0000, 32'(d[17]));
      poll(A_CMD, 17, 1'b1);
    end
    rd(A_CV);
    chk("cleared", 32'h0000_0000, d);
    chk("landings", 32'h0000_0002, 32'(n_land));
    cyc(1'b1, A_UP, 32'h0000_0004, '0);
    cyc(1'b1, A_CMD, 32'h0000_0001, '0);
    poll(A_ST, 16, 1'b1);
    cyc(1'b1, A_CMD, 32'h0000_0002, '0);
    poll(A_CMD, 16, 1'b0);
    cyc(1'b1, A_ST, VLD, '0);
    st = '0;
    // Random flags, clears, masks and writes to the view; reserved bits stay zero.
    for (i = 0; i < 24; i++) begin
      ev = $urandom;
      cyc(1'b0, A_CMD, '0, ev & 32'h0000_3F3F);
      st = st | (ev & 32'h0000_3F3F);
      mk = $urandom & VLD;
      cyc(1'b1, A_MK, mk, '0);
      rd(A_MK);
      chk("mask", mk & VLD, d);
      ev = $urandom & VLD;
      cyc(1'b1, A_ST, ev, '0);
      st = st & ~ev;
      cyc(1'b1, A_VW, ~ev & VLD, '0);
      rd(A_ST);
      chk("status", st, d);
      rd(A_VW);
      chk("view", view_of(st, mk), d);
      chk("irq", 32'(|view_of(st, mk)), 32'(o_irq));
    end
    cyc(1'b1, A_ST, VLD, 32'h0000_0001);
    rd(A_ST);
    chk("set beats clear", 32'h0000_0001, d);
    cyc(1'b1, A_ST, VLD, '0);
    cyc(1'b0, A_CMD, '0, 32'h0200_0000);
    cyc(1'b0, A_CMD, '0, 32'h2200_0000);
    rd(A_ST);
    chk("taken in time", 32'h0000_0000, d);
    cyc(1'b0, A_CMD, '0, 32'h0300_0000);
    cyc(1'b0, A_CMD, '0, 32'h0300_0000);
    rd(A_ST);
    chk("overrun", 32'h0300_0000, d);
    // The mask lands at the edge that ends the write, so look just after it.
    cyc(1'b1, A_MK, '0, '0);
    #1;
    chk("irq open", 32'h0000_0001, 32'(o_irq));
    cyc(1'b1, A_MK, VLD, '0);
    #1;
    chk("irq shut", 32'h0000_0000, 32'(o_irq));
    results();
  end
endmodule
